//--- roa_pkg.sv
// package: constants and types for the redundant output arbiter
package roa_pkg;
  localparam int NUM_OUT = 16;
  localparam logic [1:0] MISS_LIMIT = 2'h3;
  localparam logic [1:0] MISS_RST = 2'h0;
  localparam logic [4:0] DEV_PRIMARY = 5'h1f;
  localparam logic [4:0] DEV_BACKUP = 5'h1e;
  localparam logic [4:0] DEV_NONE = 5'h00;
  typedef enum logic [1:0] {
    ROA_IDLE = 2'h0,
    ROA_PRI  = 2'h1,
    ROA_BCK  = 2'h3,
    ROA_MON  = 2'h2
  } roa_fan_t;
  typedef enum logic [1:0] {
    ROA_SRC_NONE = 2'h0,
    ROA_SRC_PRI  = 2'h1,
    ROA_SRC_BCK  = 2'h2,
    ROA_SRC_VOTE = 2'h3
  } roa_src_t;
endpackage

//--- redundant_output_arbiter.sv
// redundant output arbiter: output source selection and fault notice fan-out
// Contract
// - In warm-backup mode outputs follow controller 31 whenever it supplies output data.
// - In warm-backup mode three consecutive missed scans from 31 hand outputs to 30 at once.
// - With neither controller supplying data, outputs take defaults or hold, as configured.
// - In warm-backup mode control returns to 31 as soon as it is online, over 30.
// - Dual-vote is only for discrete blocks and compares both controllers per output.
// - In dual-vote, agreeing commands drive the output to that value.
// - In dual-vote, differing commands drive the output to its mismatch value.
// - In dual-vote, if one controller stops, the remaining one drives outputs directly.
// - A redundant block sends each fault and setup notice twice, once per controller.
// - After a monitor assignment, a redundant block sends a third copy of each notice to the monitor.
// - A diagnostics query from any controller is answered with diagnostic data.
// - Input data is broadcast once per bus scan on the attached bus.
// - A controller is online while fewer than three consecutive scans pass without its output-control message; the arbiter starts it offline at reset.
`timescale 1ns/1ps
module redundant_output_arbiter
(
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic                        cfgRedundant,
  input  wire logic                        cfgDualVote,
  input  wire logic                        cfgHoldLast,
  input  wire logic [roa_pkg::NUM_OUT-1:0] cfgDefault,
  input  wire logic [roa_pkg::NUM_OUT-1:0] cfgMismatch,
  input  wire logic                        scanTick,
  input  wire logic                        msgPriValid,
  input  wire logic [roa_pkg::NUM_OUT-1:0] msgPriData,
  input  wire logic                        msgBckValid,
  input  wire logic [roa_pkg::NUM_OUT-1:0] msgBckData,
  input  wire logic                        noticeReq,
  output logic                             noticeReady,
  output logic                             noticeSend,
  output logic [4:0]                       noticeDest,
  input  wire logic                        monAssign,
  input  wire logic [4:0]                  monAssignDev,
  input  wire logic                        diagQuery,
  input  wire logic [4:0]                  diagQueryDev,
  output logic                             diagReply,
  output logic [4:0]                       diagReplyDest,
  output logic                             inputBcast,
  output logic [roa_pkg::NUM_OUT-1:0]      outData,
  output logic [1:0]                       outSource,
  output logic                             priOnline,
  output logic                             bckOnline
);
  logic [1:0] priMiss_r, priMiss_nxt, bckMiss_r, bckMiss_nxt;
  logic [roa_pkg::NUM_OUT-1:0] priCmd_r, priCmd_nxt, bckCmd_r, bckCmd_nxt;
  logic [roa_pkg::NUM_OUT-1:0] outData_r, outData_nxt;
  logic [1:0] src_r, src_nxt;
  logic monValid_r, monValid_nxt;
  logic [4:0] monDev_r, monDev_nxt;
  roa_pkg::roa_fan_t fan_r, fan_nxt;
  logic noticeSend_r, noticeSend_nxt;
  logic [4:0] noticeDest_r, noticeDest_nxt;
  logic diagReply_r, diagReply_nxt;
  logic [4:0] diagDest_r, diagDest_nxt;
  logic bcast_r, bcast_nxt;
  logic priUp, bckUp;
  logic [roa_pkg::NUM_OUT-1:0] voteBits;
  default clocking cbChk @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // a controller counts as online while fewer than three scans passed without its message; reset loads the limit, so it starts offline
  function automatic logic isUp(input logic [1:0] miss);
    isUp = (miss < roa_pkg::MISS_LIMIT);
  endfunction

  assign priUp = isUp(priMiss_r);
  assign bckUp = isUp(bckMiss_r);

  // per-output vote; generate keeps one clear equation per bit
  genvar gi;
  generate
    for (gi = 0; gi < roa_pkg::NUM_OUT; gi++)
    begin : g_vote
      assign voteBits[gi] = (priCmd_r[gi] == bckCmd_r[gi]) ? priCmd_r[gi]
                                                           : cfgMismatch[gi];
    end
  endgenerate

  always_comb
  begin
    priMiss_nxt = priMiss_r;
    bckMiss_nxt = bckMiss_r;
    priCmd_nxt = priCmd_r;
    bckCmd_nxt = bckCmd_r;
    // receipt clears, a finished scan without receipt counts; receipt wins a tie
    if (msgPriValid)
    begin
      priMiss_nxt = roa_pkg::MISS_RST;
      priCmd_nxt = msgPriData;
    end
    else if (scanTick && priMiss_r != roa_pkg::MISS_LIMIT)
      priMiss_nxt = priMiss_r + 2'h1;
    if (msgBckValid)
    begin
      bckMiss_nxt = roa_pkg::MISS_RST;
      bckCmd_nxt = msgBckData;
    end
    else if (scanTick && bckMiss_r != roa_pkg::MISS_LIMIT)
      bckMiss_nxt = bckMiss_r + 2'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      priMiss_r <= roa_pkg::MISS_LIMIT;
      bckMiss_r <= roa_pkg::MISS_LIMIT;
      priCmd_r <= '0;
      bckCmd_r <= '0;
    end
    else
    begin
      priMiss_r <= priMiss_nxt;
      bckMiss_r <= bckMiss_nxt;
      priCmd_r <= priCmd_nxt;
      bckCmd_r <= bckCmd_nxt;
    end
  end

  always_comb
  begin
    src_nxt = roa_pkg::ROA_SRC_NONE;
    outData_nxt = cfgHoldLast ? outData_r : cfgDefault;
    if (cfgDualVote && priUp && bckUp)
    begin
      src_nxt = roa_pkg::ROA_SRC_VOTE;
      outData_nxt = voteBits;
    end
    else if (priUp)
    begin
      src_nxt = roa_pkg::ROA_SRC_PRI;
      outData_nxt = priCmd_r;
    end
    else if (bckUp)
    begin
      src_nxt = roa_pkg::ROA_SRC_BCK;
      outData_nxt = bckCmd_r;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      src_r <= roa_pkg::ROA_SRC_NONE;
      outData_r <= '0;
    end
    else
    begin
      src_r <= src_nxt;
      outData_r <= outData_nxt;
    end
  end

  // notice fan-out: one copy per cycle, primary, then if redundant backup, then monitor if assigned
  always_comb
  begin
    fan_nxt = fan_r;
    noticeSend_nxt = 1'b0;
    noticeDest_nxt = noticeDest_r;
    monValid_nxt = monValid_r;
    monDev_nxt = monDev_r;
    if (monAssign)
    begin
      monValid_nxt = 1'b1;
      monDev_nxt = monAssignDev;
    end
    case (fan_r)
      roa_pkg::ROA_IDLE:
        if (noticeReq)
        begin
          noticeSend_nxt = 1'b1;
          noticeDest_nxt = roa_pkg::DEV_PRIMARY;
          fan_nxt = cfgRedundant ? roa_pkg::ROA_PRI : roa_pkg::ROA_IDLE;
        end
      roa_pkg::ROA_PRI:
      begin
        noticeSend_nxt = 1'b1;
        noticeDest_nxt = roa_pkg::DEV_BACKUP;
        fan_nxt = monValid_r ? roa_pkg::ROA_BCK : roa_pkg::ROA_IDLE;
      end
      roa_pkg::ROA_BCK:
      begin
        noticeSend_nxt = 1'b1;
        noticeDest_nxt = monDev_r;
        fan_nxt = roa_pkg::ROA_IDLE;
      end
      default:
        fan_nxt = roa_pkg::ROA_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      fan_r <= roa_pkg::ROA_IDLE;
      noticeSend_r <= 1'b0;
      noticeDest_r <= roa_pkg::DEV_NONE;
      monValid_r <= 1'b0;
      monDev_r <= roa_pkg::DEV_NONE;
    end
    else
    begin
      fan_r <= fan_nxt;
      noticeSend_r <= noticeSend_nxt;
      noticeDest_r <= noticeDest_nxt;
      monValid_r <= monValid_nxt;
      monDev_r <= monDev_nxt;
    end
  end

  always_comb
  begin
    diagReply_nxt = diagQuery;
    diagDest_nxt = diagQuery ? diagQueryDev : diagDest_r;
    bcast_nxt = scanTick;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      diagReply_r <= 1'b0;
      diagDest_r <= roa_pkg::DEV_NONE;
      bcast_r <= 1'b0;
    end
    else
    begin
      diagReply_r <= diagReply_nxt;
      diagDest_r <= diagDest_nxt;
      bcast_r <= bcast_nxt;
    end
  end

  assign noticeReady = (fan_r == roa_pkg::ROA_IDLE);
  assign noticeSend = noticeSend_r;
  assign noticeDest = noticeDest_r;
  assign diagReply = diagReply_r;
  assign diagReplyDest = diagDest_r;
  assign inputBcast = bcast_r;
  assign outData = outData_r;
  assign outSource = src_r;
  assign priOnline = priUp;
  assign bckOnline = bckUp;

  sequence s_twoCopies;
    noticeSend && noticeDest == roa_pkg::DEV_PRIMARY
      ##1 noticeSend && noticeDest == roa_pkg::DEV_BACKUP;
  endsequence
  property p_priDrives;
    msgPriValid && !cfgDualVote |=> ##1 (outData == $past(msgPriData, 2));
  endproperty
  a_priDrives: assert property (p_priDrives) else $error("primary data not driven");
  property p_failover;
    (priMiss_r == roa_pkg::MISS_LIMIT) && bckUp && !cfgDualVote
      |=> outSource == roa_pkg::ROA_SRC_BCK;
  endproperty
  a_failover: assert property (p_failover) else $error("no switch to backup");
  property p_noneDefault;
    !priUp && !bckUp && !cfgHoldLast |=> outData == $past(cfgDefault);
  endproperty
  a_noneDefault: assert property (p_noneDefault) else $error("default not applied");
  property p_revert;
    priUp && !cfgDualVote |=> outSource == roa_pkg::ROA_SRC_PRI;
  endproperty
  a_revert: assert property (p_revert) else $error("primary lacks priority");
  property p_vote;
    cfgDualVote && priUp && bckUp
      |=> outData == $past((priCmd_r & bckCmd_r) | ((priCmd_r ^ bckCmd_r) & cfgMismatch));
  endproperty
  a_vote: assert property (p_vote) else $error("vote result wrong");
  property p_mismatch;
    cfgDualVote && priUp && bckUp && (priCmd_r != bckCmd_r)
      |=> ((outData ^ $past(cfgMismatch)) & $past(priCmd_r ^ bckCmd_r)) == '0;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch value wrong");
  property p_twoCopies;
    noticeReq && noticeReady && cfgRedundant |=> s_twoCopies;
  endproperty
  a_twoCopies: assert property (p_twoCopies) else $error("notice not doubled");
  property p_diag;
    diagQuery |=> diagReply && diagReplyDest == $past(diagQueryDev);
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic query unanswered");
  property p_miss;
    msgPriValid |=> priMiss_r == roa_pkg::MISS_RST;
  endproperty
  a_miss: assert property (p_miss) else $error("miss counter not cleared");
endmodule

//--- roa_ctl_model.sv
// model of the two redundant bus controllers and the bus scan tick
`timescale 1ns/1ps
module roa_ctl_model
#(
  parameter int SCAN = 8
)
(
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic                        priOn,
  input  wire logic                        bckOn,
  input  wire logic [roa_pkg::NUM_OUT-1:0] priCmd,
  input  wire logic [roa_pkg::NUM_OUT-1:0] bckCmd,
  output logic                             scanTick,
  output logic                             msgPriValid,
  output logic [roa_pkg::NUM_OUT-1:0]      msgPriData,
  output logic                             msgBckValid,
  output logic [roa_pkg::NUM_OUT-1:0]      msgBckData
);
  int  cnt;
  wire last = (cnt == SCAN - 1) && !reset;

  initial
  begin
    cnt = 0;
    scanTick = 1'h0;
    msgPriValid = 1'h0;
    msgBckValid = 1'h0;
    msgPriData = '0;
    msgBckData = '0;
  end

  // only these two controllers ever send output data to the block
  // messages ride on the tick so a receipt always beats the miss count
  always @(negedge core_clk)
  begin
    cnt <= reset ? 0 : (cnt + 1) % SCAN;
    scanTick <= last;
    msgPriValid <= last && priOn;
    msgBckValid <= last && bckOn;
    // idle data toggles so a stale value is never mistaken for a command
    msgPriData <= (last && priOn) ? priCmd : ~msgPriData;
    msgBckData <= (last && bckOn) ? bckCmd : ~msgBckData;
  end
endmodule

//--- redundant_output_arbiter_tb_top.sv
// self-checking bench for the redundant output arbiter
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    cmpCount++; \
    if ((a) !== (e)) \
    begin \
      numErrors++; \
      $display("unexpected at %0t: got %h exp %h", $time, a, e); \
    end \
  end
module redundant_output_arbiter_tb_top;
  localparam int W = roa_pkg::NUM_OUT;
  logic         core_clk, reset, cfgRedundant, cfgDualVote, cfgHoldLast, scanTick;
  logic         msgPriValid, msgBckValid, noticeReq, noticeReady, noticeSend;
  logic         monAssign, diagQuery, diagReply, inputBcast, priOnline, bckOnline;
  logic         priOn, bckOn;
  logic [4:0]   noticeDest, monAssignDev, diagQueryDev, diagReplyDest, monDev;
  logic [1:0]   outSource;
  logic [W-1:0] cfgDefault, cfgMismatch, msgPriData, msgBckData, outData, priCmd, bckCmd;
  logic [5:0]   expQ[$];
  logic [5:0]   e, eDiag;
  int           numErrors, cmpCount;
  int           seed = 32'hc1a6178a;

  redundant_output_arbiter DUT (.*);
  roa_ctl_model ctl (.*);

  initial
  begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial
  begin
    #2000000;
    hang();
  end

  task automatic endOfTest();
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic hang();
    numErrors++;
    endOfTest();
  endtask

  task automatic waitTick(input int n);
    int k;
    repeat (n)
    begin
      k = 0;
      do
      begin
        @(negedge core_clk);
        k++;
      end while (!scanTick && k < 50);
      if (k == 50)
        hang();
    end
  endtask

  task automatic waitReady();
    int k;
    k = 0;
    while (noticeReady !== 1'h1 && k < 50)
    begin
      @(negedge core_clk);
      k++;
    end
    if (k == 50)
      hang();
  endtask

  task automatic chkOut(input logic [1:0] s, input logic [W-1:0] d);
    repeat (3) @(negedge core_clk);
    `CHK(outSource, s)
    `CHK(outData, d)
  endtask

  // request held a second cycle while busy: that one must be dropped
  task automatic sendNote(input int n);
    waitReady();
    noticeReq <= 1'h1;
    expQ.push_back({1'h0, roa_pkg::DEV_PRIMARY});
    if (n > 1)
      expQ.push_back({1'h0, roa_pkg::DEV_BACKUP});
    if (n > 2)
      expQ.push_back({1'h0, monDev});
    @(negedge core_clk);
    `CHK(noticeReady, n == 1)
    // a lone copy leaves the fan-out idle, so a held request would be taken again
    if (n > 1)
      @(negedge core_clk);
    noticeReq <= 1'h0;
    waitReady();
    repeat (2) @(negedge core_clk);
    `CHK(expQ.size() == 0, 1'b1)
  endtask

  always @(negedge core_clk)
  begin
    if (!reset)
    begin
      if (noticeSend === 1'h1)
      begin
        e = expQ.size() ? expQ.pop_front() : 'x;
        `CHK({1'h0, noticeDest}, e)
      end
      if (diagReply === 1'h1)
      begin
        e = expQ.size() ? expQ.pop_front() : 'x;
        `CHK({1'h1, diagReplyDest}, e)
      end
      `CHK(inputBcast, scanTick)
    end
  end

  initial
  begin
    reset = 1'h1;
    cfgRedundant = 1'h1;
    cfgDualVote = 1'h0;
    cfgHoldLast = 1'h1;
    cfgDefault = W'($random(seed));
    cfgMismatch = W'($random(seed));
    priCmd = W'($random(seed));
    bckCmd = W'($random(seed));
    priOn = 1'h1;
    bckOn = 1'h1;
    {noticeReq, monAssign, diagQuery} = 3'h0;
    {monAssignDev, diagQueryDev, monDev} = 15'h0000;
    repeat (5) @(negedge core_clk);
    reset <= 1'h0;
    repeat (3)
    begin
      waitTick(1);
      priCmd <= W'($random(seed));
      waitTick(1);
      chkOut(roa_pkg::ROA_SRC_PRI, priCmd);
    end
    priOn <= 1'h0;
    waitTick(2);
    `CHK(priOnline, 1'h1)
    chkOut(roa_pkg::ROA_SRC_PRI, priCmd);
    waitTick(1);
    chkOut(roa_pkg::ROA_SRC_BCK, bckCmd);
    priOn <= 1'h1;
    waitTick(1);
    chkOut(roa_pkg::ROA_SRC_PRI, priCmd);
    $display("test warm backup done");
    priOn <= 1'h0;
    bckOn <= 1'h0;
    waitTick(3);
    chkOut(roa_pkg::ROA_SRC_NONE, priCmd);
    cfgHoldLast <= 1'h0;
    chkOut(roa_pkg::ROA_SRC_NONE, cfgDefault);
    $display("test no controller done");
    cfgDualVote <= 1'h1;
    priOn <= 1'h1;
    bckOn <= 1'h1;
    repeat (4)
    begin
      priCmd <= W'($random(seed));
      bckCmd <= W'($random(seed));
      waitTick(1);
      chkOut(roa_pkg::ROA_SRC_VOTE, (priCmd & bckCmd) | ((priCmd ^ bckCmd) & cfgMismatch));
    end
    bckOn <= 1'h0;
    waitTick(3);
    `CHK(bckOnline, 1'h0)
    repeat (3) @(negedge core_clk);
    `CHK(outData, priCmd)
    bckOn <= 1'h1;
    priOn <= 1'h0;
    waitTick(3);
    repeat (3) @(negedge core_clk);
    `CHK(outData, bckCmd)
    $display("test dual vote done");
    cfgRedundant <= 1'h0;
    sendNote(1);
    cfgRedundant <= 1'h1;
    sendNote(2);
    monDev = 5'h01 + (5'($random(seed)) & 5'h0f);
    monAssignDev <= monDev;
    monAssign <= 1'h1;
    @(negedge core_clk);
    monAssign <= 1'h0;
    sendNote(3);
    $display("test notices done");
    repeat (3)
    begin
      eDiag = {1'h1, 5'($random(seed))};
      diagQueryDev <= eDiag[4:0];
      diagQuery <= 1'h1;
      expQ.push_back(eDiag);
      @(negedge core_clk);
      diagQuery <= 1'h0;
      repeat (3) @(negedge core_clk);
    end
    `CHK(expQ.size() == 0, 1'b1)
    $display("test diagnostics done");
    endOfTest();
  end
endmodule
